// *** pkg/aisel_pkg.sv ***
package aisel_pkg;
    // Register indexes on the plain register port
    localparam logic [3:0] IDX_BUF_LEN = 4'h0;
    localparam logic [3:0] IDX_MULTI_SEL = 4'h1;
    localparam logic [3:0] IDX_FIRST_SEL = 4'h2;
    localparam logic [3:0] IDX_SCAN_HIGH = 4'h3;
    localparam logic [3:0] IDX_SCAN_LOW = 4'h4;
    localparam logic [3:0] IDX_PIN_CFG_HIGH = 4'h5;
    localparam logic [3:0] IDX_CONTROL = 4'h6;
    localparam logic [3:0] IDX_STATUS = 4'h7;

    // Buffer length field
    localparam int BUF_LEN_LSB = 0;
    localparam int BUF_LEN_W = 3;
    localparam int BUF_WORDS_W = 8;
    localparam logic [7:0] BUF_WORDS_ONE = 8'h01;

    // Channel 1-3 select fields
    localparam int MULTI_POS_A_BIT = 0;
    localparam int MULTI_NEG_A_LSB = 1;
    localparam int MULTI_POS_B_BIT = 8;
    localparam int MULTI_NEG_B_LSB = 9;
    localparam logic [1:0] MULTI_NEG_HIGH_SET = 2'h3;
    localparam logic [1:0] MULTI_NEG_MID_SET = 2'h2;

    // Channel 0 select fields
    localparam int FIRST_POS_A_LSB = 0;
    localparam int FIRST_NEG_A_BIT = 7;
    localparam int FIRST_POS_B_LSB = 8;
    localparam int FIRST_NEG_B_BIT = 15;
    localparam int INPUT_IDX_W = 5;

    // Control and status bits
    localparam int CTRL_HIRES_BIT = 0;
    localparam int CTRL_ALT_BIT = 1;
    localparam int CTRL_SCAN_BIT = 2;
    localparam int CTRL_DISABLE_BIT = 3;
    localparam int STAT_PHASE_BIT = 0;
    localparam int STAT_PTR_LSB = 8;

    localparam int HALF_INPUTS = 16;
    localparam int MAX_INPUTS = 32;
    localparam logic [15:0] REG_ZERO = 16'h0000;

    // Negative input choice for channels 1-3
    typedef enum {
        AISEL_NEG_REF,
        AISEL_NEG_MID,
        AISEL_NEG_HIGH
    } aisel_neg_t;

    // Selection presented to the converter multiplexers
    typedef struct packed {
        logic [4:0] first_pos;
        logic first_pos_ref;
        logic first_pos_gnd;
        logic first_neg_an1;
        logic multi_enable;
        logic multi_pos_high;
        logic [1:0] multi_neg;
        logic sample_b;
    } aisel_sel_t;
endpackage : aisel_pkg

// *** rtl/aisel_top.sv ***
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ns
// Behaviour
// - Buffer length code n gives 2**n DMA words per input, 1 to 128.
// - Sample A channel 1-3 positive bit set picks inputs 3-5, clear 0-2.
// - Sample A negative code 11 picks 9-11, 10 picks 6-8, 0x the reference.
// - Sample B channel 1-3 fields decode like Sample A when B is active.
// - In 12-bit mode the channel 1-3 select fields read as zero.
// - Sample A channel 0 negative bit set picks input 1, clear the reference.
// - Sample A channel 0 positive field value n picks analog input n.
// - Sample B channel 0 fields decode exactly like Sample A.
// - Second instance accepts only inputs 0 to 15 as channel 0 positive.
// - Each scan mask bit includes its input in the scan; low 0-15, high 16-31, high ignored on the second instance.
// - Scan bits of absent inputs are writable; scanning them converts the reference.
// - Set pin bit: digital, port read on, mux grounded; clear: analog sampling.
// - Pin bits of absent inputs stay writable but have no effect.
// - Second instance has no high pin configuration register.
// - Module disabled: pin bits ignored, every shared pin digital.
// - Scan applies only to channel 0 positive in Sample A with scan enabled.
// - Alternate mode uses A then B selections in turn, else always A.
// - Resolution bit set gives 12-bit single channel, clear 10-bit four channels.
module aisel_top #(
    parameter int NUM_INPUTS = 32,
    parameter bit SECOND_INSTANCE = 1'b0
) (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic CE,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic SAMPLE_DONE,
    input wire logic [15:0] LOW_PIN_DIGITAL,
    output logic [15:0] RDATA,
    output logic [7:0] BUF_WORDS,
    output logic [15:0] HIGH_PIN_DIGITAL,
    output logic FOUR_CHANNEL,
    output aisel_pkg::aisel_sel_t SEL
);
    // Refuse builds the select logic cannot serve, at elaboration
    if (NUM_INPUTS < 1 || NUM_INPUTS > aisel_pkg::MAX_INPUTS) begin : g_bad_count
        $error("NUM_INPUTS out of range");
    end
    if (SECOND_INSTANCE && NUM_INPUTS > aisel_pkg::HALF_INPUTS) begin : g_bad_second
        $error("Second instance serves at most 16 inputs");
    end

    logic [2:0] buf_len_q;
    logic multi_pos_sel_a_q, multi_pos_sel_b_q;
    logic [1:0] multi_neg_sel_a_q, multi_neg_sel_b_q;
    logic [4:0] first_pos_sel_a_q, first_pos_sel_b_q;
    logic first_neg_sel_a_q, first_neg_sel_b_q;
    logic [15:0] scan_mask_high_q, scan_mask_low_q, pin_cfg_high_q;
    logic high_resolution_select_q, alternate_sample_enable_q;
    logic scan_enable_q, module_disable_q;
    logic phase_b_q;
    logic [4:0] scan_ptr_q, scan_ptr_d;
    logic [31:0] scan_include_mask, all_digital;
    logic [15:0] high_digital_d, rdata_d;
    logic [31:0] present;
    aisel_pkg::aisel_sel_t sel_d;
    logic wr_en, rd_en;

    assign wr_en = CE && WR;
    assign rd_en = CE && RD;

    // Which inputs exist on this part
    genvar gi;
    generate
        for (gi = 0; gi < aisel_pkg::MAX_INPUTS; gi++) begin : g_present
            assign present[gi] = (gi < NUM_INPUTS);
        end
    endgenerate

    // Buffer length register
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            buf_len_q <= 3'h0;
        end else if (wr_en && ADDR == aisel_pkg::IDX_BUF_LEN) begin
            buf_len_q <= WDATA[aisel_pkg::BUF_LEN_LSB +: aisel_pkg::BUF_LEN_W];
        end
    end

    // Channel 1-3 select register; bits still held in 12-bit mode, reads and SEL hide them
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            multi_pos_sel_a_q <= 1'b0;
            multi_neg_sel_a_q <= 2'h0;
            multi_pos_sel_b_q <= 1'b0;
            multi_neg_sel_b_q <= 2'h0;
        end else if (wr_en && ADDR == aisel_pkg::IDX_MULTI_SEL) begin
            multi_pos_sel_a_q <= WDATA[aisel_pkg::MULTI_POS_A_BIT];
            multi_neg_sel_a_q <= WDATA[aisel_pkg::MULTI_NEG_A_LSB +: 2];
            multi_pos_sel_b_q <= WDATA[aisel_pkg::MULTI_POS_B_BIT];
            multi_neg_sel_b_q <= WDATA[aisel_pkg::MULTI_NEG_B_LSB +: 2];
        end
    end

    // Channel 0 select register
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            first_pos_sel_a_q <= 5'h00;
            first_neg_sel_a_q <= 1'b0;
            first_pos_sel_b_q <= 5'h00;
            first_neg_sel_b_q <= 1'b0;
        end else if (wr_en && ADDR == aisel_pkg::IDX_FIRST_SEL) begin
            first_pos_sel_a_q <= WDATA[aisel_pkg::FIRST_POS_A_LSB +: aisel_pkg::INPUT_IDX_W];
            first_neg_sel_a_q <= WDATA[aisel_pkg::FIRST_NEG_A_BIT];
            first_pos_sel_b_q <= WDATA[aisel_pkg::FIRST_POS_B_LSB +: aisel_pkg::INPUT_IDX_W];
            first_neg_sel_b_q <= WDATA[aisel_pkg::FIRST_NEG_B_BIT];
            if (SECOND_INSTANCE) begin
                first_pos_sel_a_q[4] <= 1'b0;
                first_pos_sel_b_q[4] <= 1'b0;
            end
        end
    end

    // Scan masks writable for every input, present or not
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            scan_mask_high_q <= aisel_pkg::REG_ZERO;
            scan_mask_low_q <= aisel_pkg::REG_ZERO;
        end else if (wr_en && ADDR == aisel_pkg::IDX_SCAN_HIGH) begin
            scan_mask_high_q <= WDATA;
        end else if (wr_en && ADDR == aisel_pkg::IDX_SCAN_LOW) begin
            scan_mask_low_q <= WDATA;
        end
    end

    // Pin bits stored even for absent pins; never stored on the second instance
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            pin_cfg_high_q <= aisel_pkg::REG_ZERO;
        end else if (wr_en && ADDR == aisel_pkg::IDX_PIN_CFG_HIGH && !SECOND_INSTANCE) begin
            pin_cfg_high_q <= WDATA;
        end
    end

    // Mode controls feeding the select logic
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            high_resolution_select_q <= 1'b0;
            alternate_sample_enable_q <= 1'b0;
            scan_enable_q <= 1'b0;
            module_disable_q <= 1'b0;
        end else if (wr_en && ADDR == aisel_pkg::IDX_CONTROL) begin
            high_resolution_select_q <= WDATA[aisel_pkg::CTRL_HIRES_BIT];
            alternate_sample_enable_q <= WDATA[aisel_pkg::CTRL_ALT_BIT];
            scan_enable_q <= WDATA[aisel_pkg::CTRL_SCAN_BIT];
            module_disable_q <= WDATA[aisel_pkg::CTRL_DISABLE_BIT];
        end
    end

    // Alternate A and B on each completed sample
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            phase_b_q <= 1'b0;
        end else if (CE) begin
            if (!alternate_sample_enable_q) begin
                phase_b_q <= 1'b0;
            end else if (SAMPLE_DONE) begin
                phase_b_q <= !phase_b_q;
            end
        end
    end

    // Scan set; second instance never scans the upper half
    assign scan_include_mask = SECOND_INSTANCE ? {aisel_pkg::REG_ZERO, scan_mask_low_q}
                                               : {scan_mask_high_q, scan_mask_low_q};

    // Next selected input above the pointer, else the lowest
    function automatic logic [4:0] next_scan(input logic [31:0] mask, input logic [4:0] ptr);
        logic [4:0] lowest, above;
        logic found_low, found_above;
        lowest = ptr;
        above = ptr;
        found_low = 1'b0;
        found_above = 1'b0;
        for (int i = 0; i < aisel_pkg::MAX_INPUTS; i++) begin
            if (mask[i] && !found_low) begin
                lowest = 5'(i);
                found_low = 1'b1;
            end
            if (mask[i] && !found_above && 5'(i) > ptr) begin
                above = 5'(i);
                found_above = 1'b1;
            end
        end
        return found_above ? above : lowest;
    endfunction : next_scan

    // Pointer steps after each Sample A conversion while scanning
    always_comb begin
        scan_ptr_d = scan_ptr_q;
        if (scan_enable_q && !phase_b_q && SAMPLE_DONE) begin
            scan_ptr_d = next_scan(scan_include_mask, scan_ptr_q);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            scan_ptr_q <= 5'h00;
        end else if (CE) begin
            scan_ptr_q <= scan_ptr_d;
        end
    end

    // Digital state of every shared pin
    generate
        for (gi = 0; gi < aisel_pkg::HALF_INPUTS; gi++) begin : g_pins
            // No high register on second instance; absent pins digital
            assign high_digital_d[gi] = module_disable_q || SECOND_INSTANCE
                || !present[gi + aisel_pkg::HALF_INPUTS] || pin_cfg_high_q[gi];
            assign all_digital[gi] = module_disable_q || LOW_PIN_DIGITAL[gi];
            assign all_digital[gi + aisel_pkg::HALF_INPUTS] = high_digital_d[gi];
        end
    endgenerate

    // Selection seen by the converter for the current sample
    always_comb begin
        sel_d = '0;
        sel_d.sample_b = phase_b_q;
        // Scan only for Sample A channel 0 positive
        if (!phase_b_q && scan_enable_q) begin
            sel_d.first_pos = scan_ptr_q;
        end else if (!phase_b_q) begin
            sel_d.first_pos = first_pos_sel_a_q;
        end else begin
            sel_d.first_pos = first_pos_sel_b_q;
        end
        sel_d.first_neg_an1 = phase_b_q ? first_neg_sel_b_q : first_neg_sel_a_q;
        sel_d.first_pos_ref = !present[sel_d.first_pos];
        sel_d.first_pos_gnd = all_digital[sel_d.first_pos];
        // Four channels only in 10-bit mode
        sel_d.multi_enable = !high_resolution_select_q;
        if (!high_resolution_select_q) begin
            // Positive group select; B fields when B active
            sel_d.multi_pos_high = phase_b_q ? multi_pos_sel_b_q : multi_pos_sel_a_q;
            sel_d.multi_neg = phase_b_q ? multi_neg_sel_b_q : multi_neg_sel_a_q;
            if (!sel_d.multi_neg[1]) begin
                sel_d.multi_neg = 2'h0;
            end
        end
    end

    // Register read mux
    always_comb begin
        rdata_d = aisel_pkg::REG_ZERO;
        case (ADDR)
            aisel_pkg::IDX_BUF_LEN: rdata_d[aisel_pkg::BUF_LEN_LSB +: 3] = buf_len_q;
            aisel_pkg::IDX_MULTI_SEL: begin
                if (!high_resolution_select_q) begin
                    rdata_d[aisel_pkg::MULTI_POS_A_BIT] = multi_pos_sel_a_q;
                    rdata_d[aisel_pkg::MULTI_NEG_A_LSB +: 2] = multi_neg_sel_a_q;
                    rdata_d[aisel_pkg::MULTI_POS_B_BIT] = multi_pos_sel_b_q;
                    rdata_d[aisel_pkg::MULTI_NEG_B_LSB +: 2] = multi_neg_sel_b_q;
                end
            end
            aisel_pkg::IDX_FIRST_SEL: begin
                rdata_d[aisel_pkg::FIRST_POS_A_LSB +: 5] = first_pos_sel_a_q;
                rdata_d[aisel_pkg::FIRST_NEG_A_BIT] = first_neg_sel_a_q;
                rdata_d[aisel_pkg::FIRST_POS_B_LSB +: 5] = first_pos_sel_b_q;
                rdata_d[aisel_pkg::FIRST_NEG_B_BIT] = first_neg_sel_b_q;
            end
            aisel_pkg::IDX_SCAN_HIGH: rdata_d = scan_mask_high_q;
            aisel_pkg::IDX_SCAN_LOW: rdata_d = scan_mask_low_q;
            aisel_pkg::IDX_PIN_CFG_HIGH: rdata_d = pin_cfg_high_q;
            aisel_pkg::IDX_CONTROL: begin
                rdata_d[aisel_pkg::CTRL_HIRES_BIT] = high_resolution_select_q;
                rdata_d[aisel_pkg::CTRL_ALT_BIT] = alternate_sample_enable_q;
                rdata_d[aisel_pkg::CTRL_SCAN_BIT] = scan_enable_q;
                rdata_d[aisel_pkg::CTRL_DISABLE_BIT] = module_disable_q;
            end
            aisel_pkg::IDX_STATUS: begin
                rdata_d[aisel_pkg::STAT_PHASE_BIT] = phase_b_q;
                rdata_d[aisel_pkg::STAT_PTR_LSB +: 5] = scan_ptr_q;
            end
            default: rdata_d = aisel_pkg::REG_ZERO;
        endcase
    end

    // Read data stands one enabled cycle, zero otherwise; held while CE is low
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            RDATA <= aisel_pkg::REG_ZERO;
        end else if (CE) begin
            RDATA <= rd_en ? rdata_d : aisel_pkg::REG_ZERO;
        end
    end

    // Registered outputs, one cycle behind the controls
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            BUF_WORDS <= aisel_pkg::BUF_WORDS_ONE;
            HIGH_PIN_DIGITAL <= aisel_pkg::REG_ZERO;
            FOUR_CHANNEL <= 1'b1;
            SEL <= '0;
        end else if (CE) begin
            BUF_WORDS <= aisel_pkg::BUF_WORDS_ONE << buf_len_q;
            HIGH_PIN_DIGITAL <= high_digital_d;
            FOUR_CHANNEL <= !high_resolution_select_q;
            SEL <= sel_d;
        end
    end

    // Checks on the registered outputs and internal registers
    a_buf_words_pow: assert property (@(posedge CLK_SYS) disable iff (SRST)
        CE |=> BUF_WORDS == (aisel_pkg::BUF_WORDS_ONE << $past(buf_len_q)))
        else $error("Buffer word count wrong");
    a_hires_read_zero: assert property (@(posedge CLK_SYS) disable iff (SRST)
        rd_en && ADDR == aisel_pkg::IDX_MULTI_SEL && high_resolution_select_q
        |=> RDATA == aisel_pkg::REG_ZERO)
        else $error("Channel 1-3 select visible in 12-bit mode");
    a_multi_neg_ref: assert property (@(posedge CLK_SYS) disable iff (SRST)
        CE && !sel_d.sample_b && !multi_neg_sel_a_q[1] |=> SEL.multi_neg == 2'h0)
        else $error("Negative group not reference");
    a_multi_pos_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        CE && !phase_b_q && !high_resolution_select_q
        |=> SEL.multi_pos_high == $past(multi_pos_sel_a_q))
        else $error("Positive group not from Sample A");
    a_alt_toggle: assert property (@(posedge CLK_SYS) disable iff (SRST)
        CE && alternate_sample_enable_q && SAMPLE_DONE ##1 CE |=> SEL.sample_b != $past(SEL.sample_b))
        else $error("Sample phase did not alternate");
    a_no_alt_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        CE && !alternate_sample_enable_q ##1 CE |=> !SEL.sample_b)
        else $error("Sample B used without alternate mode");
    a_disable_digital: assert property (@(posedge CLK_SYS) disable iff (SRST)
        CE && module_disable_q |=> HIGH_PIN_DIGITAL == 16'hffff)
        else $error("Disabled module left a pin analog");
    a_second_low_half: assert property (@(posedge CLK_SYS) disable iff (SRST)
        SECOND_INSTANCE |-> !first_pos_sel_a_q[4] && !first_pos_sel_b_q[4])
        else $error("Second instance holds an upper input");
    a_scan_first_pos: assert property (@(posedge CLK_SYS) disable iff (SRST)
        CE && scan_enable_q && !phase_b_q |=> SEL.first_pos == $past(scan_ptr_q))
        else $error("Scan pointer not used in Sample A");
    a_scan_in_mask: assert property (@(posedge CLK_SYS) disable iff (SRST)
        CE && scan_enable_q && !phase_b_q && SAMPLE_DONE && !wr_en
        && (scan_include_mask != 32'h0)
        |=> scan_include_mask[scan_ptr_q])
        else $error("Scan stepped to an unselected input");
endmodule : aisel_top

// *** dv/tb_aisel_top.sv ***
`timescale 1ns/1ns
module tb_aisel_top;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sample_done = 1'b0;
    logic [15:0] low_pin = 16'h0000;
    logic [15:0] rdata, rdata2, high_pin, high_pin2;
    logic [7:0] buf_words;
    logic four_ch;
    aisel_pkg::aisel_sel_t sel, sel2;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] lfsr_q = 32'h502c;
    logic [15:0] mdl [8] = '{default: 16'h0000};
    logic phase_b = 1'b0;
    int ptr = 0;
    int ptr2 = 0;

    // Free-running system clock, 20 ns
    always #10 clk_sys = ~clk_sys;

    aisel_top i_dut (.CLK_SYS(clk_sys), .SRST(srst), .CE(ce), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .SAMPLE_DONE(sample_done), .LOW_PIN_DIGITAL(low_pin),
        .RDATA(rdata), .BUF_WORDS(buf_words), .HIGH_PIN_DIGITAL(high_pin),
        .FOUR_CHANNEL(four_ch), .SEL(sel));

    // Second converter with only 12 inputs fitted, shares the bus
    aisel_top #(.NUM_INPUTS(12), .SECOND_INSTANCE(1'b1)) i_dut2 (.CLK_SYS(clk_sys),
        .SRST(srst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .SAMPLE_DONE(sample_done), .LOW_PIN_DIGITAL(low_pin), .RDATA(rdata2),
        .BUF_WORDS(), .HIGH_PIN_DIGITAL(high_pin2), .FOUR_CHANNEL(), .SEL(sel2));

    function automatic logic [15:0] rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q[15:0];
    endfunction : rnd

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Readback model: unimplemented bits zero, 12-bit mode hides channel 1-3 fields
    function automatic logic [15:0] exp_rd(input logic [3:0] a);
        case (a)
            4'h0: return mdl[0] & 16'h0007;
            4'h1: return mdl[6][0] ? 16'h0000 : (mdl[1] & 16'h0707);
            4'h2: return mdl[2] & 16'h9f9f;
            4'h3, 4'h4, 4'h5: return mdl[a[2:0]];
            4'h6: return mdl[6] & 16'h000f;
            4'h7: return {3'h0, ptr[4:0], 7'h00, phase_b};
            default: return 16'h0000;
        endcase
    endfunction : exp_rd

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        if (ce && a < 4'h7) mdl[a[2:0]] = d;
        if (ce && a == aisel_pkg::IDX_CONTROL && !d[1]) phase_b = 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, output logic [15:0] v, output logic [15:0] v2);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        @(negedge clk_sys);
        v = rdata;
        v2 = rdata2;
    endtask : reg_rd

    // Registers land one edge late and outputs follow one edge later still
    task automatic settle;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle

    // One finished sample; pointer only steps after a Sample A with scan on
    task automatic pulse;
        logic was_b;
        logic [31:0] m;
        was_b = phase_b;
        m = {mdl[3], mdl[4]};
        @(posedge clk_sys);
        sample_done <= 1'b1;
        @(posedge clk_sys);
        sample_done <= 1'b0;
        if (mdl[6][1]) phase_b = ~phase_b;
        if (mdl[6][2] && !was_b) begin
            for (int i = 1; i <= 32; i++) if (m[(ptr + i) % 32]) begin
                ptr = (ptr + i) % 32;
                break;
            end
            for (int i = 1; i <= 16; i++) if (m[(ptr2 + i) % 16]) begin
                ptr2 = (ptr2 + i) % 16;
                break;
            end
        end
        settle;
    endtask : pulse

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("mismatch at %0t: timeout", $time);
            finish_test();
        end
    end

    initial begin
        logic [15:0] v, v2, r, lo;
        logic [4:0] fp;
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        settle;
        chk({8'h00, buf_words}, 16'h0001, "reset words");
        chk({15'h0000, four_ch}, 16'h0001, "reset mode");
        for (int a = 0; a < 10; a++) begin
            reg_rd(a[3:0], v, v2);
            chk(v, exp_rd(a[3:0]), "reset read");
        end
        $display("reset test done");
        for (int c = 0; c < 8; c++) begin
            reg_wr(aisel_pkg::IDX_BUF_LEN, 16'hfff8 | c[15:0]);
            settle;
            chk({8'h00, buf_words}, 16'h0001 << c, "buffer words");
            reg_rd(aisel_pkg::IDX_BUF_LEN, v, v2);
            chk(v, exp_rd(aisel_pkg::IDX_BUF_LEN), "buffer code");
        end
        for (int c = 0; c < 8; c++) begin
            reg_wr(aisel_pkg::IDX_MULTI_SEL, {13'h0000, c[2:0]});
            settle;
            chk({15'h0000, sel.multi_pos_high}, {15'h0000, c[0]}, "multi pos");
            chk({14'h0000, sel.multi_neg}, {14'h0000, c[2] ? c[2:1] : 2'h0}, "mneg");
            chk({15'h0000, sel.multi_enable}, 16'h0001, "four channel");
        end
        for (int n = 0; n < 32; n++) begin
            reg_wr(aisel_pkg::IDX_FIRST_SEL, {8'h00, n[1], 2'h0, n[4:0]});
            settle;
            chk({11'h000, sel.first_pos}, n[15:0], "first pos");
            chk({15'h0000, sel.first_neg_an1}, {15'h0000, n[1]}, "first neg");
            chk({11'h000, sel2.first_pos}, {12'h000, n[3:0]}, "second pos");
        end
        $display("decode test done");
        reg_wr(aisel_pkg::IDX_MULTI_SEL, 16'h0401);
        reg_wr(aisel_pkg::IDX_FIRST_SEL, 16'h8a07);
        reg_wr(aisel_pkg::IDX_CONTROL, 16'h0002);
        for (int k = 0; k < 4; k++) begin
            pulse;
            chk({15'h0000, sel.sample_b}, {15'h0000, phase_b}, "phase");
            chk({11'h000, sel.first_pos}, phase_b ? 16'h000a : 16'h0007, "alt pos");
            chk({15'h0000, sel.first_neg_an1}, {15'h0000, phase_b}, "alt neg");
            chk({15'h0000, sel.multi_pos_high}, {15'h0000, !phase_b}, "alt mpos");
            chk({14'h0000, sel.multi_neg}, phase_b ? 16'h0002 : 16'h0000, "mneg b");
            reg_rd(aisel_pkg::IDX_STATUS, v, v2);
            chk(v, exp_rd(aisel_pkg::IDX_STATUS), "status");
        end
        reg_wr(aisel_pkg::IDX_CONTROL, 16'h0001);
        settle;
        chk({15'h0000, four_ch}, 16'h0000, "single mode");
        chk({12'h000, sel.multi_enable, sel.multi_pos_high, sel.multi_neg}, 16'h0000,
            "hidden");
        reg_rd(aisel_pkg::IDX_MULTI_SEL, v, v2);
        chk(v, exp_rd(aisel_pkg::IDX_MULTI_SEL), "hidden read");
        reg_wr(aisel_pkg::IDX_CONTROL, 16'h0000);
        reg_rd(aisel_pkg::IDX_MULTI_SEL, v, v2);
        chk(v, exp_rd(aisel_pkg::IDX_MULTI_SEL), "held read");
        $display("sample test done");
        r = rnd();
        lo = rnd();
        @(posedge clk_sys);
        low_pin <= lo;
        reg_wr(aisel_pkg::IDX_PIN_CFG_HIGH, r);
        reg_wr(aisel_pkg::IDX_FIRST_SEL, 16'h0014);
        settle;
        chk(high_pin, r, "pin mode");
        chk({15'h0000, sel.first_pos_gnd}, {15'h0000, r[4]}, "mux ground");
        chk(high_pin2, 16'hffff, "no high pins");
        reg_rd(aisel_pkg::IDX_PIN_CFG_HIGH, v, v2);
        chk(v, r, "pin read");
        chk(v2, 16'h0000, "no high reg");
        reg_wr(aisel_pkg::IDX_FIRST_SEL, 16'h0003);
        settle;
        chk({15'h0000, sel.first_pos_gnd}, {15'h0000, lo[3]}, "low ground");
        reg_wr(aisel_pkg::IDX_CONTROL, 16'h0008);
        settle;
        chk(high_pin, 16'hffff, "disabled pins");
        chk({15'h0000, sel.first_pos_gnd}, 16'h0001, "disabled ground");
        $display("pin test done");
        reg_wr(aisel_pkg::IDX_SCAN_LOW, 16'h2024);
        reg_wr(aisel_pkg::IDX_SCAN_HIGH, 16'h0002);
        reg_wr(aisel_pkg::IDX_CONTROL, 16'h0004);
        settle;
        for (int k = 0; k < 10; k++) begin
            if (k == 6) reg_wr(aisel_pkg::IDX_CONTROL, 16'h0006);
            pulse;
            fp = phase_b ? mdl[2][12:8] : ptr[4:0];
            chk({11'h000, sel.first_pos}, {11'h000, fp}, "scan pos");
            chk({11'h000, sel2.first_pos}, phase_b ? 16'h0000 : ptr2[15:0], "scan2");
            chk({15'h0000, sel2.first_pos_ref}, {15'h0000, !phase_b && ptr2 >= 12},
                "absent ref");
            reg_rd(aisel_pkg::IDX_STATUS, v, v2);
            chk(v, exp_rd(aisel_pkg::IDX_STATUS), "scan order");
        end
        $display("scan test done");
        // Enable low: the write is dropped, so the word count must hold at 128
        @(posedge clk_sys);
        ce <= 1'b0;
        reg_wr(aisel_pkg::IDX_BUF_LEN, 16'h0002);
        @(posedge clk_sys);
        ce <= 1'b1;
        settle;
        chk({8'h00, buf_words}, 16'h0080, "frozen words");
        reg_rd(aisel_pkg::IDX_BUF_LEN, v, v2);
        chk(v, exp_rd(aisel_pkg::IDX_BUF_LEN), "frozen code");
        $display("enable test done");
        finish_test();
    end
endmodule : tb_aisel_top
